// ==== hw/strr_params.svh ====
// Purpose: register offsets, field positions and reset values of the slot trigger router
// Assumes: byte addresses on an 8-bit register port, 32-bit data
// Notes:   every slot owns a block of four words starting at STRR_OFF_SLOT_BASE
`ifndef STRR_PARAMS_SVH
`define STRR_PARAMS_SVH

`define STRR_NSLOT          4
`define STRR_OFF_CONFIG     8'h00
`define STRR_OFF_KIND       8'h04
`define STRR_OFF_WLEN       8'h08
`define STRR_OFF_SPF        8'h0c
`define STRR_OFF_SLOT_BASE  4'h1
`define STRR_SUB_RESP       2'h0
`define STRR_SUB_OCOND      2'h1
`define STRR_SUB_FUNC       2'h2
`define STRR_SUB_STATUS     2'h3

`define STRR_FUNC_ARM_BIT   0
`define STRR_LOOP_LSB       8
`define STRR_ST_BUSY_BIT    8
`define STRR_ST_ARMED_BIT   9
`define STRR_ST_FUNC_BIT    10
`define STRR_ST_INVAL_BIT   11

`define STRR_RST_CONFIG     2'h1
`define STRR_RST_KIND       8'h00
`define STRR_RST_WLEN       16'h0010
`define STRR_RST_SPF        8'h04
`define STRR_RST_LOOPS      8'h01

`endif

// ==== hw/strr_pkg.sv ====
// Purpose: types shared by the slot trigger router modules
// Assumes: constants live in strr_params.svh
// Notes:   none
package strr_pkg;

  typedef enum logic [1:0] {
    RESP_IGNORE                  = 2'h0,
    SINGLE_SAMPLE_ON_TRIGGER     = 2'h1,
    FULL_FUNCTION_ON_TRIGGER     = 2'h2,
    REPEATED_FUNCTION_ON_TRIGGER = 2'h3
  } strr_resp_t;

  typedef enum logic [1:0] {
    OUT_NEVER            = 2'h0,
    PULSE_AT_WINDOW_END  = 2'h1,
    OUT_AT_WINDOW_BEGIN  = 2'h2,
    OUT_RESERVED         = 2'h3
  } strr_ocond_t;

  typedef enum logic [1:0] {
    KIND_MULTIPORT = 2'h0,
    KIND_SINGLE_PM = 2'h1,
    KIND_ATTEN     = 2'h2,
    KIND_RESERVED  = 2'h3
  } strr_kind_t;

  typedef enum logic [1:0] {
    CFG_DISABLED            = 2'h0,
    CFG_DEFAULT             = 2'h1,
    FORWARD_INPUT_TO_OUTPUT = 2'h2,
    LEGACY_FORWARD_ALIAS    = 2'h3
  } strr_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } strr_state_t;

endpackage

// ==== hw/strr_slot_if.sv ====
// Purpose: carries settings into one slot engine and its events back out
// Assumes: single clock domain
// Notes:   event signals are one-cycle pulses
`timescale 1ns/10ps
interface strr_slot_if;
  strr_pkg::strr_resp_t resp;
  strr_pkg::strr_kind_t kind;
  logic [15:0]          wlen;
  logic [7:0]           spf;
  logic [7:0]           loops;
  logic                 cfg_wr;
  logic                 func_arm;
  logic                 trig;
  logic                 armed;
  logic                 func_armed;
  logic                 busy;
  logic                 win_begin;
  logic                 win_end;
  logic                 sample;
  logic                 invalid;
  logic [7:0]           taken;

  modport ctl  (output resp, kind, wlen, spf, loops, cfg_wr, func_arm, trig,
                input armed, func_armed, busy, win_begin, win_end, sample, invalid, taken);
  modport eng  (input resp, kind, wlen, spf, loops, cfg_wr, func_arm, trig,
                output armed, func_armed, busy, win_begin, win_end, sample, invalid, taken);
endinterface

// ==== hw/strr_slot.sv ====
// Purpose: per-slot measurement sequencer reacting to trigger events
// Assumes: settings stable while a function runs
// Notes:   a window length of zero is run as one cycle
`timescale 1ns/10ps
`include "strr_params.svh"
module strr_slot (
  // clock and reset
  input wire logic     clk,
  input wire logic     rst,
  // settings and events
  strr_slot_if.eng     sif
);
  strr_pkg::strr_state_t state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic [7:0]  left_q, left_d, loop_q, loop_d, taken_q, taken_d;
  logic        armed_q, armed_d, func_q, func_d, inval_q, inval_d, single_q, single_d;
  logic        beg_q, beg_d, end_q, end_d, smp_q, smp_d, bad_q, bad_d;
  logic [15:0] wl;
  logic [7:0]  spf1;
  logic        qual, start;

  always_comb begin
    wl = (sif.wlen == 16'h0000) ? 16'h0001 : sif.wlen;
    spf1 = (sif.spf == 8'h00) ? 8'h01 : sif.spf;
    qual = 1'b0;
    case (sif.kind)
      strr_pkg::KIND_ATTEN:     qual = 1'b0;
      strr_pkg::KIND_SINGLE_PM: qual = armed_q && sif.trig && sif.resp != strr_pkg::RESP_IGNORE;
      default:                  qual = armed_q && sif.trig && sif.resp != strr_pkg::RESP_IGNORE
                                       && (func_q || sif.func_arm);
    endcase
    start = qual || (sif.kind == strr_pkg::KIND_ATTEN);
    state_d = state_q; cnt_d = cnt_q; left_d = left_q; loop_d = loop_q; taken_d = taken_q;
    armed_d = armed_q || sif.cfg_wr;
    func_d = func_q; inval_d = inval_q; single_d = single_q;
    beg_d = 1'b0; end_d = 1'b0; smp_d = 1'b0; bad_d = 1'b0;
    if (sif.func_arm) begin
      func_d = 1'b1;
      taken_d = 8'h00;
      // trigger racing the arm gives an unreliable first value
      if (sif.trig) inval_d = 1'b1;
    end
    case (state_q)
      strr_pkg::ST_IDLE: begin
        if (start) begin
          state_d = strr_pkg::ST_RUN;
          cnt_d = wl;
          beg_d = 1'b1;
          single_d = 1'b0;
          loop_d = 8'h01;
          left_d = spf1;
          if (sif.kind == strr_pkg::KIND_ATTEN) begin
            left_d = 8'h01;
          end else if (sif.resp == strr_pkg::SINGLE_SAMPLE_ON_TRIGGER &&
                       sif.kind == strr_pkg::KIND_MULTIPORT) begin
            left_d = 8'h01;
            single_d = 1'b1;
          end else if (sif.resp == strr_pkg::REPEATED_FUNCTION_ON_TRIGGER &&
                       sif.loops > 8'h01) begin
            loop_d = sif.loops;
          end
        end
      end
      strr_pkg::ST_RUN: begin
        cnt_d = cnt_q - 16'h0001;
        if (cnt_q == 16'h0001) begin
          end_d = 1'b1;
          smp_d = 1'b1;
          bad_d = inval_q;
          // a racing arm in this very cycle keeps its flag: set wins over clear
          if (!(sif.func_arm && sif.trig)) inval_d = 1'b0;
          taken_d = taken_q + 8'h01;
          if (left_q > 8'h01) begin
            left_d = left_q - 8'h01;
            cnt_d = wl;
            beg_d = 1'b1;
          end else if (loop_q > 8'h01) begin
            loop_d = loop_q - 8'h01;
            left_d = spf1;
            cnt_d = wl;
            beg_d = 1'b1;
          end else begin
            state_d = strr_pkg::ST_IDLE;
            if (sif.kind == strr_pkg::KIND_MULTIPORT &&
                (!single_q || taken_q + 8'h01 >= spf1) && !sif.func_arm) begin
              func_d = 1'b0;
            end
          end
        end
      end
      default: state_d = strr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= strr_pkg::ST_IDLE;
      cnt_q   <= 16'h0000;
      left_q  <= 8'h00;
      loop_q  <= 8'h00;
      taken_q <= 8'h00;
      armed_q <= 1'b0;
      func_q  <= 1'b0;
      inval_q <= 1'b0;
      single_q <= 1'b0;
      beg_q   <= 1'b0;
      end_q   <= 1'b0;
      smp_q   <= 1'b0;
      bad_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      left_q  <= left_d;
      loop_q  <= loop_d;
      taken_q <= taken_d;
      armed_q <= armed_d;
      func_q  <= func_d;
      inval_q <= inval_d;
      single_q <= single_d;
      beg_q   <= beg_d;
      end_q   <= end_d;
      smp_q   <= smp_d;
      bad_q   <= bad_d;
    end
  end

  assign sif.armed      = armed_q;
  assign sif.func_armed = func_q;
  assign sif.busy       = (state_q == strr_pkg::ST_RUN);
  assign sif.win_begin  = beg_q;
  assign sif.win_end    = end_q;
  assign sif.sample     = smp_q;
  assign sif.invalid    = bad_q;
  assign sif.taken      = taken_q;
endmodule

// ==== hw/strr_top.sv ====
// Purpose: routes the trigger input connector to four slot engines and picks the output trigger source
// Assumes: TRIG_IN_I may be asynchronous; register port strobes are one cycle
// Notes:   read data stand in the cycle after the read strobe only
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`include "strr_params.svh"
// How it works
// - single-sample response takes one sample per trigger on multiport slots
// - full-function response runs the whole function
// - repeated response loops function without new triggers
// - repeat count one equals full-function response
// - attenuator slots ignore response, measure continuously
// - single-channel meters need no armed function
// - multiport slots need an armed function first
// - armed slot acts on every qualifying trigger that arrives while idle
// - trigger during arming flags first value invalid
// - writing output condition stores it and arms
// - output condition: never, window end, window begin
// - lowest enabled channel drives the output connector
// - config zero disables both connectors
// - config one enables input and slot outputs
// - config two also forwards input to output
// - config three behaves as config two
// - every setting reads back
// - writing input response stores it and arms
module strr_top (
  // clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        RST_I,
  // register port
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WE_I,
  input  wire logic        RE_I,
  output logic      [31:0] RDATA_O,
  // trigger connectors
  input  wire logic        TRIG_IN_I,
  output logic             TRIG_OUT_O,
  // per-slot sample events
  output logic      [3:0]  SAMPLE_O,
  output logic      [3:0]  SAMPLE_INVALID_O
);
  localparam int NS = `STRR_NSLOT;

  strr_pkg::strr_cfg_t   cfg_q, cfg_d;
  strr_pkg::strr_resp_t  resp_q  [NS];
  strr_pkg::strr_resp_t  resp_d  [NS];
  strr_pkg::strr_ocond_t ocond_q [NS];
  strr_pkg::strr_ocond_t ocond_d [NS];
  logic [7:0]  loops_q [NS];
  logic [7:0]  loops_d [NS];
  logic [7:0]  kind_q, kind_d, spf_q, spf_d;
  logic [15:0] wlen_q, wlen_d;
  logic [31:0] rdata_q, rdata_d;
  logic        sync1_q, sync2_q, sync3_q;
  logic        tout_q, tout_d;
  logic [3:0]  smp_q, smp_d, bad_q, bad_d;
  logic        trig_evt;
  logic [NS-1:0] cfg_wr, func_arm;
  logic [NS-1:0] ev_begin, ev_end, ev_smp, ev_bad, st_busy, st_armed, st_func;
  logic [7:0]  st_taken [NS];

  strr_slot_if sif [NS] ();

  // slot block index, or NS when the address is outside the slot area
  function automatic logic [2:0] slot_of(input logic [7:0] a);
    logic [3:0] blk;
    blk = a[7:4] - `STRR_OFF_SLOT_BASE;
    slot_of = (a[7:4] >= `STRR_OFF_SLOT_BASE && blk < 4'(NS)) ? blk[2:0] : 3'(NS);
  endfunction

  function automatic logic hits(input logic [7:0] a, input int s, input logic [1:0] sub);
    hits = (slot_of(a) == 3'(s)) && (a[3:2] == sub) && (a[1:0] == 2'h0);
  endfunction

  // input connector synchroniser; the second and third stages feed the edge detector
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= TRIG_IN_I;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // disabled connectors swallow the input event entirely
  assign trig_evt = sync2_q && !sync3_q && (cfg_q != strr_pkg::CFG_DISABLED);

  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : gs
      assign cfg_wr[g]   = WE_I && (hits(ADDR_I, g, `STRR_SUB_RESP) || hits(ADDR_I, g, `STRR_SUB_OCOND));
      assign func_arm[g] = WE_I && hits(ADDR_I, g, `STRR_SUB_FUNC) && WDATA_I[`STRR_FUNC_ARM_BIT];
      assign sif[g].resp     = resp_q[g];
      assign sif[g].kind     = strr_pkg::strr_kind_t'(kind_q[2*g +: 2]);
      assign sif[g].wlen     = wlen_q;
      assign sif[g].spf      = spf_q;
      assign sif[g].loops    = loops_q[g];
      assign sif[g].cfg_wr   = cfg_wr[g];
      assign sif[g].func_arm = func_arm[g];
      assign sif[g].trig     = trig_evt;
      assign ev_begin[g] = sif[g].win_begin;
      assign ev_end[g]   = sif[g].win_end;
      assign ev_smp[g]   = sif[g].sample;
      assign ev_bad[g]   = sif[g].invalid;
      assign st_busy[g]  = sif[g].busy;
      assign st_armed[g] = sif[g].armed;
      assign st_func[g]  = sif[g].func_armed;
      assign st_taken[g] = sif[g].taken;
      strr_slot u_slot (
        .clk (MCLK_I),
        .rst (RST_I),
        .sif (sif[g])
      );
    end
  endgenerate

  // register writes and read-back
  always_comb begin
    cfg_d = cfg_q;
    kind_d = kind_q;
    wlen_d = wlen_q;
    spf_d = spf_q;
    rdata_d = 32'h0000_0000;
    for (int s = 0; s < NS; s++) begin
      resp_d[s] = resp_q[s];
      ocond_d[s] = ocond_q[s];
      loops_d[s] = loops_q[s];
    end
    if (WE_I) begin
      case (ADDR_I)
        `STRR_OFF_CONFIG: cfg_d = strr_pkg::strr_cfg_t'(WDATA_I[1:0]);
        `STRR_OFF_KIND:   kind_d = WDATA_I[7:0];
        `STRR_OFF_WLEN:   wlen_d = WDATA_I[15:0];
        `STRR_OFF_SPF:    spf_d = WDATA_I[7:0];
        default: ;
      endcase
      for (int s = 0; s < NS; s++) begin
        if (hits(ADDR_I, s, `STRR_SUB_RESP)) resp_d[s] = strr_pkg::strr_resp_t'(WDATA_I[1:0]);
        if (hits(ADDR_I, s, `STRR_SUB_OCOND)) ocond_d[s] = strr_pkg::strr_ocond_t'(WDATA_I[1:0]);
        if (hits(ADDR_I, s, `STRR_SUB_FUNC)) loops_d[s] = WDATA_I[`STRR_LOOP_LSB +: 8];
      end
    end
    if (RE_I) begin
      case (ADDR_I)
        `STRR_OFF_CONFIG: rdata_d = {30'h0, cfg_q};
        `STRR_OFF_KIND:   rdata_d = {24'h0, kind_q};
        `STRR_OFF_WLEN:   rdata_d = {16'h0, wlen_q};
        `STRR_OFF_SPF:    rdata_d = {24'h0, spf_q};
        default: ;
      endcase
      for (int s = 0; s < NS; s++) begin
        if (hits(ADDR_I, s, `STRR_SUB_RESP)) rdata_d = {30'h0, resp_q[s]};
        if (hits(ADDR_I, s, `STRR_SUB_OCOND)) rdata_d = {30'h0, ocond_q[s]};
        if (hits(ADDR_I, s, `STRR_SUB_FUNC)) rdata_d = {16'h0, loops_q[s], 7'h0, st_func[s]};
        if (hits(ADDR_I, s, `STRR_SUB_STATUS)) begin
          rdata_d = {24'h0, st_taken[s]};
          rdata_d[`STRR_ST_BUSY_BIT]  = st_busy[s];
          rdata_d[`STRR_ST_ARMED_BIT] = st_armed[s];
          rdata_d[`STRR_ST_FUNC_BIT]  = st_func[s];
          rdata_d[`STRR_ST_INVAL_BIT] = ev_bad[s];
        end
      end
    end
  end

  // output trigger: first enabled channel wins, later ones are never looked at
  always_comb begin
    logic found;
    logic slot_ev;
    found = 1'b0;
    slot_ev = 1'b0;
    for (int s = 0; s < NS; s++) begin
      if (!found && ocond_q[s] != strr_pkg::OUT_NEVER) begin
        found = 1'b1;
        case (ocond_q[s])
          strr_pkg::PULSE_AT_WINDOW_END: slot_ev = ev_end[s];
          strr_pkg::OUT_AT_WINDOW_BEGIN: slot_ev = ev_begin[s];
          default:                       slot_ev = 1'b0;
        endcase
      end
    end
    case (cfg_q)
      strr_pkg::CFG_DISABLED:            tout_d = 1'b0;
      strr_pkg::CFG_DEFAULT:             tout_d = slot_ev;
      strr_pkg::FORWARD_INPUT_TO_OUTPUT: tout_d = slot_ev || trig_evt;
      strr_pkg::LEGACY_FORWARD_ALIAS:    tout_d = slot_ev || trig_evt;
      default:                           tout_d = 1'b0;
    endcase
    smp_d = ev_smp;
    bad_d = ev_bad;
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      cfg_q   <= strr_pkg::strr_cfg_t'(`STRR_RST_CONFIG);
      kind_q  <= `STRR_RST_KIND;
      wlen_q  <= `STRR_RST_WLEN;
      spf_q   <= `STRR_RST_SPF;
      rdata_q <= 32'h0000_0000;
      tout_q  <= 1'b0;
      smp_q   <= 4'h0;
      bad_q   <= 4'h0;
      for (int s = 0; s < NS; s++) begin
        resp_q[s]  <= strr_pkg::RESP_IGNORE;
        ocond_q[s] <= strr_pkg::OUT_NEVER;
        loops_q[s] <= `STRR_RST_LOOPS;
      end
    end else begin
      cfg_q   <= cfg_d;
      kind_q  <= kind_d;
      wlen_q  <= wlen_d;
      spf_q   <= spf_d;
      rdata_q <= rdata_d;
      tout_q  <= tout_d;
      smp_q   <= smp_d;
      bad_q   <= bad_d;
      for (int s = 0; s < NS; s++) begin
        resp_q[s]  <= resp_d[s];
        ocond_q[s] <= ocond_d[s];
        loops_q[s] <= loops_d[s];
      end
    end
  end

  assign RDATA_O          = rdata_q;
  assign TRIG_OUT_O       = tout_q;
  assign SAMPLE_O         = smp_q;
  assign SAMPLE_INVALID_O = bad_q;
endmodule

// ==== tb/strr_monitor.sv ====
// Purpose: port checker for the slot trigger router
// Assumes: settings are shadowed from register writes
// Notes:   bound to strr_top at the foot of this file
`timescale 1ns/10ps
`include "strr_params.svh"
module strr_monitor (
  input wire logic        MCLK_I,
  input wire logic        RST_I,
  input wire logic [7:0]  ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic        WE_I,
  input wire logic        RE_I,
  input wire logic [31:0] RDATA_O,
  input wire logic        TRIG_IN_I,
  input wire logic        TRIG_OUT_O,
  input wire logic [3:0]  SAMPLE_O,
  input wire logic [3:0]  SAMPLE_INVALID_O
);
  logic [1:0] cfg_q;
  logic [7:0] kind_q;
  logic [3:0] arm_q, farm_q, atn, mp;
  logic [2:0] off_q;
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      cfg_q  <= 2'h1;
      kind_q <= 8'h00;
      arm_q  <= 4'h0;
      farm_q <= 4'h0;
      off_q  <= 3'h0;
    end else begin
      if (WE_I && ADDR_I == `STRR_OFF_CONFIG) cfg_q <= WDATA_I[1:0];
      if (WE_I && ADDR_I == `STRR_OFF_KIND) kind_q <= WDATA_I[7:0];
      // saturating count of cycles spent with connectors off
      off_q <= (cfg_q != 2'h0) ? 3'h0 : (off_q == 3'h7) ? 3'h7 : off_q + 3'h1;
      for (int n = 0; n < 4; n++) begin
        if (WE_I && ADDR_I[7:4] == 4'(n + 1) && ADDR_I[1:0] == 2'h0) begin
          if (!ADDR_I[3]) arm_q[n] <= 1'b1;
          if (ADDR_I[3:2] == 2'h2 && WDATA_I[0]) farm_q[n] <= 1'b1;
        end
      end
    end
  end
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      atn[n] = kind_q[2*n +: 2] == 2'h2;
      mp[n]  = kind_q[2*n +: 2] == 2'h0;
    end
  end
  property p_rd_idle;
    (RDATA_O != 32'h0) |-> $past(RE_I);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");
  property p_rd_cfg;
    (RE_I && ADDR_I == `STRR_OFF_CONFIG) |=> (RDATA_O == {30'h0, $past(cfg_q)});
  endproperty
  a_rd_cfg: assert property (p_rd_cfg) else $error("config read back wrong");
  property p_rd_map;
    (RE_I && ADDR_I == 8'h50) |=> (RDATA_O == 32'h0);
  endproperty
  a_rd_map: assert property (p_rd_map) else $error("unmapped read not zero");
  property p_inval;
    (SAMPLE_INVALID_O & ~SAMPLE_O) == 4'h0;
  endproperty
  a_inval: assert property (p_inval) else $error("invalid flag without sample");
  property p_arm;
    (SAMPLE_O & ~(arm_q | atn)) == 4'h0;
  endproperty
  a_arm: assert property (p_arm) else $error("sample on unarmed slot");
  property p_mp;
    (SAMPLE_O & mp & ~farm_q) == 4'h0;
  endproperty
  a_mp: assert property (p_mp) else $error("multiport sample without function");
  property p_off;
    (off_q == 3'h7) |-> !TRIG_OUT_O;
  endproperty
  a_off: assert property (p_off) else $error("output trigger while disabled");
  property p_fwd;
    (cfg_q[1] && $rose(TRIG_IN_I)) |-> ##[2:4] TRIG_OUT_O;
  endproperty
  a_fwd: assert property (p_fwd) else $error("input not forwarded");
endmodule
bind strr_top strr_monitor u_mon (.MCLK_I(MCLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WE_I(WE_I), .RE_I(RE_I), .RDATA_O(RDATA_O), .TRIG_IN_I(TRIG_IN_I), .TRIG_OUT_O(TRIG_OUT_O),
  .SAMPLE_O(SAMPLE_O), .SAMPLE_INVALID_O(SAMPLE_INVALID_O));

// ==== tb/strr_ext_equip.sv ====
// Purpose: external equipment on both trigger connectors
// Assumes: fire_i is a one-cycle request from the bench
// Notes:   a request while the pulse is high is dropped
`timescale 1ns/10ps
module strr_ext_equip (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // requests from the bench
  input  wire logic        fire_i,
  input  wire logic [3:0]  hold_i,
  // connectors
  input  wire logic        trig_out_i,
  output logic             trig_in_o,
  output logic      [15:0] out_cnt_o
);
  logic [3:0] left_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_in_o <= 1'b0;
      left_q    <= 4'h0;
      out_cnt_o <= 16'h0;
    end else begin
      if (trig_out_i) out_cnt_o <= out_cnt_o + 16'h1;
      // the line drops for at least a cycle so each pulse is a fresh edge
      if (fire_i && !trig_in_o) begin
        trig_in_o <= 1'b1;
        left_q    <= hold_i;
      end else begin
        trig_in_o <= trig_in_o && left_q > 4'h1;
        left_q    <= (left_q == 4'h0) ? 4'h0 : left_q - 4'h1;
      end
    end
  end
endmodule

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the slot trigger router
// Assumes: pulse counts are differences of running totals
// Notes:   timeout after 20000 cycles
`timescale 1ns/10ps
`include "strr_params.svh"
module testbench;
  logic        clk = 1'b0, rst = 1'b1, we = 1'b0, re = 1'b0, fire = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [3:0]  hold = 4'h1, samp, inval;
  logic        tin, tout;
  logic [15:0] outs;
  int          num_errors = 0, tests_run = 0, cyc = 0, seed = 32'h08a6;
  int          sc[4] = '{0, 0, 0, 0}, ic[4] = '{0, 0, 0, 0};
  int          t_s0, t_out, b, o, k, c1;
  always #2.5 clk = ~clk;
  strr_top dut (.MCLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WE_I(we), .RE_I(re),
    .RDATA_O(rdata), .TRIG_IN_I(tin), .TRIG_OUT_O(tout), .SAMPLE_O(samp), .SAMPLE_INVALID_O(inval));
  strr_ext_equip ext (.clk_i(clk), .rst_i(rst), .fire_i(fire), .hold_i(hold), .trig_out_i(tout),
    .trig_in_o(tin), .out_cnt_o(outs));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (int n = 0; n < 4; n++) begin
      sc[n] <= sc[n] + samp[n];
      ic[n] <= ic[n] + inval[n];
    end
    if (samp[0]) t_s0 <= cyc;
    if (tout) t_out <= cyc;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    rv = rdata;
  endtask
  task automatic chkrd(input logic [7:0] a, input logic [31:0] e, input string what);
    rd(a);
    chk(what, e, rv);
  endtask
  function automatic logic [7:0] sa(input int s, input logic [1:0] sub);
    return {4'(s + 1), sub, 2'h0};
  endfunction
  task automatic trig();
    @(posedge clk);
    fire <= 1'b1;
    hold <= 4'(1 + ($random(seed) & 3));
    @(posedge clk);
    fire <= 1'b0;
  endtask
  // bounded poll of the slot busy flag
  task automatic idle(input int s);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 200; i++) begin
      rd(sa(s, `STRR_SUB_STATUS));
      if (rv[`STRR_ST_BUSY_BIT] === 1'b0) break;
    end
    chk("idle", 32'h0, 32'(rv[`STRR_ST_BUSY_BIT]));
    repeat (4) @(posedge clk);
  endtask
  task automatic run(input int s, input int n);
    b = sc[s];
    trig();
    idle(s);
    chk("samples", 32'(b + n), 32'(sc[s]));
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    chkrd(`STRR_OFF_CONFIG, 32'h1, "config");
    chkrd(`STRR_OFF_SPF, 32'h4, "spf");
    chkrd(8'h50, 32'h0, "unmapped");
    for (int s = 0; s < 4; s++) begin
      chkrd(sa(s, `STRR_SUB_RESP), 32'h0, "resp");
      chkrd(sa(s, `STRR_SUB_OCOND), 32'h0, "ocond");
      chkrd(sa(s, `STRR_SUB_FUNC), 32'h100, "func");
    end
    wr(`STRR_OFF_WLEN, 32'h2);
    wr(`STRR_OFF_SPF, 32'h3);
    wr(sa(0, `STRR_SUB_RESP), 32'h2);
    chkrd(sa(0, `STRR_SUB_RESP), 32'h2, "resp");
    run(0, 0);
    wr(sa(0, `STRR_SUB_FUNC), 32'h101);
    run(0, 3);
    chkrd(sa(0, `STRR_SUB_STATUS), 32'h203, "status");
    run(0, 0);
    wr(sa(1, `STRR_SUB_RESP), 32'h1);
    wr(sa(1, `STRR_SUB_FUNC), 32'h101);
    k = 1 + ($random(seed) & 1);
    for (int i = 0; i < k; i++) run(1, 1);
    wr(sa(1, `STRR_SUB_RESP), 32'h3);
    for (int l = 1; l < 3; l++) begin
      k = (l == 1) ? 1 : 2 + ($random(seed) & 1);
      wr(sa(1, `STRR_SUB_FUNC), 32'(k * 256 + 1));
      run(1, 3 * k);
      chkrd(sa(1, `STRR_SUB_FUNC), 32'(k * 256), "loops");
    end
    wr(`STRR_OFF_KIND, 32'h10);
    wr(sa(2, `STRR_SUB_RESP), 32'h1);
    run(2, 3);
    c1 = sc[2] - b;
    chk("meter any", 32'h1, 32'(c1 != 0));
    wr(sa(2, `STRR_SUB_RESP), 32'h2);
    run(2, c1);
    wr(`STRR_OFF_SPF, 32'h1);
    for (int c = 0; c < 4; c++) begin
      wr(`STRR_OFF_CONFIG, 32'(c));
      chkrd(`STRR_OFF_CONFIG, 32'(c), "config");
      wr(sa(0, `STRR_SUB_FUNC), 32'h101);
      o = outs;
      run(0, (c != 0) ? 1 : 0);
      repeat (8) @(posedge clk);
      chk("forward", 32'(o + (c >= 2)), 32'(outs));
    end
    wr(`STRR_OFF_CONFIG, 32'h1);
    wr(`STRR_OFF_WLEN, 32'h8);
    for (int c = 0; c < 3; c++) begin
      wr(sa(0, `STRR_SUB_OCOND), 32'(c));
      chkrd(sa(0, `STRR_SUB_OCOND), 32'(c), "ocond");
      wr(sa(0, `STRR_SUB_FUNC), 32'h101);
      o = outs;
      run(0, 1);
      chk("out count", 32'(o + (c != 0)), 32'(outs));
      if (c != 0) chk("out lead", 32'((c == 2) ? 8 : 0), 32'(t_s0 - t_out));
    end
    wr(sa(0, `STRR_SUB_OCOND), 32'h1);
    wr(sa(1, `STRR_SUB_OCOND), 32'h1);
    for (int c = 0; c < 2; c++) begin
      wr(sa(1, `STRR_SUB_FUNC), 32'h101);
      o = outs;
      run(1, 1);
      chk("owner", 32'(o + c), 32'(outs));
      wr(sa(0, `STRR_SUB_OCOND), 32'h0);
    end
    wr(sa(1, `STRR_SUB_RESP), 32'h0);
    wr(sa(1, `STRR_SUB_FUNC), 32'h101);
    run(1, 0);
    // reserved code still owns the connector but emits nothing
    wr(sa(0, `STRR_SUB_OCOND), 32'h3);
    wr(sa(1, `STRR_SUB_RESP), 32'h2);
    o = outs;
    run(1, 1);
    chk("owner", 32'(o), 32'(outs));
    // arm lands on the edge where the synchronised input edge appears
    b = ic[0];
    trig();
    @(posedge clk);
    wr(sa(0, `STRR_SUB_FUNC), 32'h101);
    idle(0);
    chk("invalid", 32'(b + 1), 32'(ic[0]));
    wr(`STRR_OFF_KIND, 32'h90);
    repeat (20) @(posedge clk);
    b = sc[3];
    repeat (100) @(posedge clk);
    // one idle cycle separates attenuator windows, so the period is WLEN plus one
    chk("atten", 32'h1, 32'((sc[3] - b) inside {[11:12]}));
    results();
  end
endmodule
